/* File: pkg/iocm_regs.vh */
// Constants for the instruction-side block memory port
`ifndef IOCM_REGS_VH
`define IOCM_REGS_VH

// ***************************************
// Field positions, big-endian bit numbers
// ***************************************
`define IOCM_BASE_MSB      0
`define IOCM_BASE_LSB      7
`define IOCM_ADDR_MSB      8
`define IOCM_ADDR_LSB      28
`define IOCM_WORD_MSB      0
`define IOCM_WORD_LSB      31
`define IOCM_LINE_MSB      0
`define IOCM_LINE_LSB      63

// ***************************************
// Reset values
// ***************************************
`define IOCM_BASE_RESET    8'h00
`define IOCM_INIT_RESET    21'h00000
`define IOCM_FILL_RESET    32'h00000000

// ***************************************
// Variant codes
// ***************************************
`define IOCM_VARIANT_WRITE_ONLY 1'b0
`define IOCM_VARIANT_READ_WRITE 1'b1

`endif

/* File: verilog/iocm_match.v */
// Base-address window match for one fetch address
`timescale 1ns/1ps
`include "iocm_regs.vh"

module iocm_match (
	input  wire [`IOCM_BASE_MSB:`IOCM_BASE_LSB] base,
	input  wire [`IOCM_BASE_MSB:`IOCM_BASE_LSB] upper_bits,
	output wire                                 hit
);

	// Eight upper bits select one 16 MB window
	assign hit = (upper_bits == base); // RL3 RL16

endmodule

/* File: verilog/iocm_port.v */
// Instruction-side on-chip memory controller, block memory port
// What this block does
// [RL1] Read enable only on valid window fetches
// [RL2] Fetch address bits 8 to 28 driven
// [RL3] Upper eight bits matched against base
// [RL4] Write-only variant: address from initial register
// [RL5] Read-write variant: one address both ways
// [RL6] 32-bit write data shared by banks
// [RL7] Write data comes from fill register
// [RL8] Odd write enable only on odd writes
// [RL9] Write-only: odd enable feeds EN and WE
// [RL10] Read-write: access enable feeds EN input
// [RL11] Single port: odd enable may float
// [RL12] Memory EN tied high or read enable
// [RL13] Second port outputs used only dual-port
// [RL14] Controller and memory on memory clock
// [RL15] Memory returns 64-bit data per fetch
// [RL16] Base register places one 16 MB window
// [RL17] Read select high picks odd word
// [RL18] Second port values change only on load
`timescale 1ns/1ps
`include "iocm_regs.vh"

module iocm_port (
	input  wire                                 clk_sys,
	input  wire                                 rst,
	input  wire                                 read_write_variant,
	input  wire                                 fetch_valid,
	input  wire [0:31]                          fetch_address,
	input  wire [`IOCM_LINE_MSB:`IOCM_LINE_LSB] fetch_read_data,
	input  wire                                 base_load,
	input  wire [`IOCM_BASE_MSB:`IOCM_BASE_LSB] base_value,
	input  wire                                 init_load,
	input  wire [`IOCM_ADDR_MSB:`IOCM_ADDR_LSB] init_value,
	input  wire                                 fill_load,
	input  wire [`IOCM_WORD_MSB:`IOCM_WORD_LSB] fill_value,
	input  wire                                 bus_write_req,
	input  wire                                 bus_read_req,
	input  wire                                 bus_odd_word,
	output reg                                  fetch_mem_read_enable,
	output reg  [`IOCM_ADDR_MSB:`IOCM_ADDR_LSB] fetch_read_address,
	output reg                                  fetch_data_valid,
	output reg  [`IOCM_LINE_MSB:`IOCM_LINE_LSB] fetch_data,
	output reg  [`IOCM_BASE_MSB:`IOCM_BASE_LSB] instr_base_address_reg,
	output reg  [`IOCM_ADDR_MSB:`IOCM_ADDR_LSB] second_port_address,
	output reg  [`IOCM_WORD_MSB:`IOCM_WORD_LSB] second_port_write_data,
	output reg                                  odd_bank_write_enable,
	output reg                                  odd_bank_access_enable,
	output reg                                  even_odd_read_select
);

	// ***************************************
	// Fetch window match
	// ***************************************
	wire                                 fetch_hit;
	wire [`IOCM_BASE_MSB:`IOCM_BASE_LSB] fetch_upper;
	wire [`IOCM_ADDR_MSB:`IOCM_ADDR_LSB] fetch_line_addr;
	wire                                 variant_reads;

	assign fetch_upper     = fetch_address[`IOCM_BASE_MSB:`IOCM_BASE_LSB]; // RL3
	assign fetch_line_addr = fetch_address[`IOCM_ADDR_MSB:`IOCM_ADDR_LSB]; // RL2
	// Write-only variant never reads through the second port
	assign variant_reads   = (read_write_variant == `IOCM_VARIANT_READ_WRITE);

	iocm_match u_match (
		.base       (instr_base_address_reg),
		.upper_bits (fetch_upper),
		.hit        (fetch_hit)
	);

	// ***************************************
	// Fetch path next values
	// ***************************************
	reg                                 next_read_enable;
	reg [`IOCM_ADDR_MSB:`IOCM_ADDR_LSB] next_read_address;
	reg                                 next_data_valid;
	reg [`IOCM_LINE_MSB:`IOCM_LINE_LSB] next_fetch_data;
	reg [`IOCM_BASE_MSB:`IOCM_BASE_LSB] next_base;

	// Fetch with old base when load and fetch coincide
	always @* begin
		next_read_enable = 1'b0;
		if (fetch_valid && fetch_hit) begin
			next_read_enable = 1'b1; // RL1 RL3
		end
	end

	// Address holds between hits
	always @* begin
		next_read_address = fetch_read_address;
		if (fetch_valid && fetch_hit) begin
			next_read_address = fetch_line_addr; // RL2
		end
	end

	// Memory answers in the cycle of its enable; valid and data register one cycle later
	always @* begin
		next_data_valid = fetch_mem_read_enable; // RL15
	end

	always @* begin
		next_fetch_data = fetch_data;
		if (fetch_mem_read_enable) begin
			next_fetch_data = fetch_read_data; // RL15
		end
	end

	always @* begin
		next_base = instr_base_address_reg;
		if (base_load) begin
			next_base = base_value; // RL16
		end
	end

	// ***************************************
	// Fetch path registers
	// ***************************************
	always @(posedge clk_sys) begin // RL14
		if (rst) begin
			fetch_mem_read_enable <= 1'b0;
		end else begin
			fetch_mem_read_enable <= next_read_enable; // RL1 RL12
		end
	end

	always @(posedge clk_sys) begin // RL14
		if (rst) begin
			fetch_read_address <= `IOCM_INIT_RESET;
		end else begin
			fetch_read_address <= next_read_address; // RL2
		end
	end

	always @(posedge clk_sys) begin // RL14
		if (rst) begin
			fetch_data_valid <= 1'b0;
			fetch_data       <= 64'h0000000000000000;
		end else begin
			fetch_data_valid <= next_data_valid; // RL15
			fetch_data       <= next_fetch_data; // RL15
		end
	end

	always @(posedge clk_sys) begin // RL14
		if (rst) begin
			instr_base_address_reg <= `IOCM_BASE_RESET;
		end else begin
			instr_base_address_reg <= next_base; // RL16
		end
	end

	// ***************************************
	// Second port next values
	// ***************************************
	reg                                 next_odd_write;
	reg                                 next_odd_access;
	reg                                 next_read_select;
	reg [`IOCM_ADDR_MSB:`IOCM_ADDR_LSB] next_port_address;
	reg [`IOCM_WORD_MSB:`IOCM_WORD_LSB] next_port_data;

	always @* begin
		next_odd_write = 1'b0;
		if (bus_write_req && bus_odd_word) begin
			next_odd_write = 1'b1; // RL8 RL13
		end
	end

	always @* begin
		next_odd_access = 1'b0;
		if (bus_odd_word && (bus_write_req || (bus_read_req && variant_reads))) begin
			next_odd_access = 1'b1; // RL10
		end
	end

	// Select holds its last value between reads
	always @* begin
		next_read_select = even_odd_read_select;
		if (bus_read_req && variant_reads) begin
			next_read_select = bus_odd_word; // RL17
		end
	end

	// Same address serves writes in both variants, reads only in the read-write variant
	always @* begin
		next_port_address = second_port_address;
		if (init_load) begin
			next_port_address = init_value; // RL4 RL5 RL18
		end
	end

	always @* begin
		next_port_data = second_port_write_data;
		if (fill_load) begin
			next_port_data = fill_value; // RL6 RL7 RL18
		end
	end

	// ***************************************
	// Second port registers
	// ***************************************
	always @(posedge clk_sys) begin // RL14
		if (rst) begin
			second_port_address    <= `IOCM_INIT_RESET;
			second_port_write_data <= `IOCM_FILL_RESET;
		end else begin
			second_port_address    <= next_port_address; // RL4 RL5
			second_port_write_data <= next_port_data; // RL6 RL7
		end
	end

	always @(posedge clk_sys) begin // RL14
		if (rst) begin
			odd_bank_write_enable  <= 1'b0;
			odd_bank_access_enable <= 1'b0;
		end else begin
			odd_bank_write_enable  <= next_odd_write; // RL8
			odd_bank_access_enable <= next_odd_access; // RL10
		end
	end

	always @(posedge clk_sys) begin // RL14
		if (rst) begin
			even_odd_read_select <= 1'b0;
		end else begin
			even_odd_read_select <= next_read_select; // RL17
		end
	end

endmodule

/* File: dv/iocm_bram_model.sv */
// Behavioural block memory behind the fetch port
`timescale 1ns/1ps
module iocm_bram_model (
	input  wire        clk_sys,
	input  wire        en,
	input  wire [8:28] addr,
	output wire [0:63] rd
);
	reg [0:63] idle = 64'h0;
	assign rd = en ? {11'h0, addr, 11'h7ff, ~addr} : idle;
	always @(posedge clk_sys) idle <= ~rd;
endmodule

/* File: dv/iocm_port_checker.sv */
// Assertion checker for the block memory port
`timescale 1ns/1ps
module iocm_port_checker (
	input wire        clk_sys,
	input wire        rst,
	input wire        fetch_valid,
	input wire        fetch_mem_read_enable,
	input wire        fetch_data_valid,
	input wire        base_load,
	input wire        init_load,
	input wire        fill_load,
	input wire        read_write_variant,
	input wire        bus_write_req,
	input wire        bus_read_req,
	input wire        bus_odd_word,
	input wire        odd_bank_write_enable,
	input wire        odd_bank_access_enable,
	input wire        even_odd_read_select,
	input wire [0:31] fetch_address,
	input wire [0:31] fill_value,
	input wire [0:31] second_port_write_data,
	input wire [0:7]  base_value,
	input wire [0:7]  instr_base_address_reg,
	input wire [8:28] fetch_read_address,
	input wire [8:28] init_value,
	input wire [8:28] second_port_address
);
	wire hit = fetch_valid && fetch_address[0:7] == instr_base_address_reg;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	rd_en_a: assert property (##1 fetch_mem_read_enable == $past(hit)) else $error("enable");
	rd_addr_a: assert property (hit |=> fetch_read_address == $past(fetch_address[8:28])) else $error("addr");
	base_a: assert property (base_load |=> instr_base_address_reg == $past(base_value)) else $error("base");
	init_a: assert property (init_load |=> second_port_address == $past(init_value)) else $error("init");
	init_hold_a: assert property (!init_load |=> $stable(second_port_address)) else $error("init hold");
	fill_a: assert property (fill_load |=> second_port_write_data == $past(fill_value)) else $error("fill");
	fill_hold_a: assert property (!fill_load |=> $stable(second_port_write_data)) else $error("fill hold");
	odd_we_a: assert property (##1 odd_bank_write_enable == $past(bus_write_req && bus_odd_word)) else $error("odd");
	odd_access_a: assert property (##1 odd_bank_access_enable == $past(bus_odd_word && (bus_write_req || (bus_read_req && read_write_variant)))) else $error("access");
	read_sel_a: assert property (bus_read_req && read_write_variant |=> even_odd_read_select == $past(bus_odd_word)) else $error("select");
	data_valid_a: assert property (##1 fetch_data_valid == $past(fetch_mem_read_enable)) else $error("valid");
endmodule
bind iocm_port iocm_port_checker chk (.*);

/* File: dv/iocm_port_tb_top.sv */
// Self-checking bench for the block memory port
`timescale 1ns/1ps
module iocm_port_tb_top;
	reg         clk_sys = 0, rst = 1, read_write_variant = 0, fetch_valid = 0, base_load = 0, init_load = 0;
	reg         fill_load = 0, bus_write_req = 0, bus_read_req = 0, bus_odd_word = 0, ee = 0, ed = 0;
	reg         ow = 0, oa = 0, es = 0;
	reg  [0:31] fetch_address = 0, fill_value = 0, wd = 0;
	reg  [0:7]  base_value = 0, eb = 0;
	reg  [8:28] init_value = 0, ea = 0, pa = 0, sa = 0;
	wire [0:63] fetch_read_data, fetch_data;
	wire [0:31] second_port_write_data;
	wire [8:28] fetch_read_address, second_port_address;
	wire [0:7]  instr_base_address_reg;
	wire        fetch_mem_read_enable, fetch_data_valid, odd_bank_write_enable, odd_bank_access_enable;
	wire        even_odd_read_select;
	int         err_total = 0, n_tests = 0, i;
	iocm_port dut (.*);
	iocm_bram_model mem (.clk_sys, .en(fetch_mem_read_enable), .addr(fetch_read_address), .rd(fetch_read_data));
	always #5 clk_sys = ~clk_sys;
	task chk(string n, logic [0:63] e, g);
		n_tests++;
		err_total += (e !== g);
		if (e !== g) $display("[ERR] %s expected %h seen %h", n, e, g);
	endtask
	task conclude;
		$display("%0d checks %0d errors", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#40000 err_total++;
		conclude;
	end
	initial begin
		i = $urandom(32'hc6730d57);
		repeat (8) @(posedge clk_sys);
		#1 rst = 0;
		for (i = 0; i < 3000; i++) begin
			@(posedge clk_sys);
			#1 chk("address", ea, fetch_read_address);
			chk("odd write", ow, odd_bank_write_enable);
			chk("odd access", oa, odd_bank_access_enable);
			chk("read select", es, even_odd_read_select);
			chk("port address", sa, second_port_address);
			chk("write data", wd, second_port_write_data);
			if (ed)
				chk("line", {11'h0, pa, 11'h7ff, ~pa}, fetch_data);
			read_write_variant = (i >= 1500);
			{fetch_valid, base_load, init_load, fill_load, bus_write_req, bus_read_req, bus_odd_word} = 7'($urandom);
			{fetch_address, base_value, init_value, fill_value} = 93'({$urandom, $urandom, $urandom});
			// Odd cycles hit the base, one in three as a near miss on the lowest base bit
			if (i % 2)
				fetch_address[0:7] = eb ^ {7'h0, i % 6 == 1};
			ed = ee;
			pa = ea;
			ee = fetch_valid && fetch_address[0:7] == eb;
			ea = ee ? fetch_address[8:28] : ea;
			eb = base_load ? base_value : eb;
			ow = bus_write_req && bus_odd_word;
			oa = bus_odd_word && (bus_write_req || (bus_read_req && read_write_variant));
			es = (bus_read_req && read_write_variant) ? bus_odd_word : es;
			sa = init_load ? init_value : sa;
			wd = fill_load ? fill_value : wd;
		end
		conclude;
	end
endmodule
